// ### cxp_fwd_pkg.sv
package cxp_fwd_pkg;

    // Lane and buffer dimensions.
    localparam int LANES      = 4;
    localparam int WORD_W     = 32;
    localparam int FIFO_DEPTH = 16;

    // Word codes seen on the serial links, control words flagged by k.
    localparam logic [31:0] IDLE_WORD = 32'h3c3c3cbc;
    localparam logic [31:0] LINE_MARK = 32'h1c1c1c1c;
    localparam logic [31:0] MSG_HDR   = 32'hfbfbfbfb;
    localparam logic [31:0] MSG_SOS   = 32'h00000001;
    localparam logic [31:0] MSG_EOS   = 32'h00000002;

    // Transmit word time at CXP-6 and the clock period, in picoseconds.
    localparam int WORD_TIME_PS  = 6400;
    localparam int CLK_PERIOD_PS = 50000;
    localparam int TX_DIV_RAW    = WORD_TIME_PS / CLK_PERIOD_PS;
    localparam int TX_DIV        = (TX_DIV_RAW < 1) ? 1 : TX_DIV_RAW;
    localparam int TXC_W         = $clog2(TX_DIV + 1);

    // Clock edges needed before the head strap is taken.
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // Lane counts that the head may have discovered.
    localparam logic [2:0] LCNT_ONE  = 3'h1;
    localparam logic [2:0] LCNT_TWO  = 3'h2;

    // Lane masks for each discovered connection count.
    localparam logic [3:0] MASK_ONE  = 4'h1;
    localparam logic [3:0] MASK_TWO  = 4'h3;
    localparam logic [3:0] MASK_FOUR = 4'hf;

    // Trigger message insertion states.
    typedef enum logic [2:0] {
        MS_IDLE = 3'b001,
        MS_HDR  = 3'b010,
        MS_CODE = 3'b100
    } msg_state_t;

endpackage

// ### fwd_word_fifo.sv
`timescale 1ns/1ps
module fwd_word_fifo
    import cxp_fwd_pkg::*;
#(
    parameter int W     = 33,
    parameter int DEPTH = 16
) (
    input  wire logic         ref_clk,   // System clock.
    input  wire logic         rst_b,     // Asynchronous reset, low.
    input  wire logic         in_valid,  // Word offered.
    output logic              in_ready,  // Room for a word.
    input  wire logic [W-1:0] in_data,   // Word written.
    output logic              out_valid, // Word available.
    input  wire logic         out_ready, // Consumer takes word.
    output logic [W-1:0]      out_data   // Oldest word.
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0]   cnt_ff;
    logic [AW-1:0] nxt_wr_ptr;
    logic [AW-1:0] nxt_rd_ptr;
    logic [AW:0]   nxt_cnt;
    logic          push;
    logic          pop;

    // Honest full and empty come straight from the fill count.
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count updates for each accepted push and pop.
    always_comb begin
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_cnt    = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // Control registers.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff    <= nxt_cnt;
        end
    end

    // Storage write; contents need no reset.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

endmodule // fwd_word_fifo

// ### cxp_data_forwarding_chain.sv
`timescale 1ns/1ps
module cxp_data_forwarding_chain
    import cxp_fwd_pkg::*;
#(
    parameter int N_LANES = LANES,
    parameter int DEPTH   = FIFO_DEPTH
) (
    input  wire logic                          ref_clk,      // 20 MHz.
    input  wire logic                          rst_b,        // Reset, low.
    input  wire logic                          head_strap,   // Head pin.
    input  wire logic [2:0]                    lane_count,   // Discovered.
    input  wire logic                          acq_en,       // Acquisition.
    input  wire logic                          cam_trig_req, // Cycle trig.
    input  wire logic                          sos_trig,     // Async pin.
    input  wire logic                          eos_trig,     // Async pin.
    input  wire logic [N_LANES-1:0]            rx_clk,       // Link clocks.
    input  wire logic [N_LANES-1:0][WORD_W-1:0] rx_data,     // Link words.
    input  wire logic [N_LANES-1:0]            rx_k,         // Control flag.
    output logic [N_LANES-1:0][WORD_W-1:0]     fwd_data,     // Out words.
    output logic [N_LANES-1:0]                 fwd_k,        // Out flags.
    output logic                               fwd_stb,      // Word slot.
    output logic [N_LANES-1:0]                 lane_mask,    // Used lanes.
    output logic [N_LANES-1:0]                 rx_overflow,  // Sticky.
    output logic                               discovery_en, // Head only.
    output logic                               h2d_trig,     // Head trig.
    output logic                               sos_evt,      // Scan start.
    output logic                               eos_evt       // Scan end.
);

    // Head strap capture.
    logic       strap_s1_ff;
    logic       strap_s2_ff;
    logic       head_ff;
    logic [1:0] cap_cnt_ff;
    logic       nxt_head;
    logic [1:0] nxt_cap_cnt;

    // Scan trigger synchronisers and pending triggers.
    logic sos_s1_ff, sos_s2_ff, sos_s3_ff;
    logic eos_s1_ff, eos_s2_ff, eos_s3_ff;
    logic pend_sos_ff, pend_eos_ff;
    logic q_sos_ff, q_eos_ff;
    logic nxt_pend_sos, nxt_pend_eos;
    logic nxt_q_sos, nxt_q_eos;
    logic sos_edge, eos_edge;

    // Message insertion state.
    msg_state_t  ms_ff;
    msg_state_t  nxt_ms;
    logic        cur_sos_ff;
    logic        nxt_cur_sos;
    logic        ins_active;
    logic [31:0] ins_word;

    // Follower message detection.
    logic det_hdr_ff;
    logic nxt_det_hdr;
    logic sos_evt_ff, eos_evt_ff;
    logic nxt_sos_evt, nxt_eos_evt;
    logic h2d_ff;
    logic nxt_h2d;

    // Transmit slot timer.
    logic [TXC_W-1:0] tx_cnt_ff;
    logic [TXC_W-1:0] nxt_tx_cnt;
    logic             slot;

    // Per-lane receive results seen by the shared logic.
    logic [N_LANES-1:0]             rx_edge;
    logic [N_LANES-1:0][WORD_W-1:0] rx_word;
    logic [N_LANES-1:0]             rx_isk;
    logic [N_LANES-1:0]             seen_ff;
    logic [N_LANES-1:0]             nxt_seen;
    logic [N_LANES-1:0]             head_mask;

    // The strap is synchronised, then caught once after reset release.
    always_comb begin
        nxt_cap_cnt = cap_cnt_ff;
        nxt_head    = head_ff;
        if (cap_cnt_ff != STRAP_WAIT) begin
            nxt_cap_cnt = cap_cnt_ff + 1'b1;
            nxt_head    = strap_s2_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
            cap_cnt_ff  <= '0;
            head_ff     <= 1'b0;
        end else begin
            strap_s1_ff <= head_strap;
            strap_s2_ff <= strap_s1_ff;
            cap_cnt_ff  <= nxt_cap_cnt;
            head_ff     <= nxt_head;
        end
    end

    // Only the head runs discovery and host-to-device triggering.
    assign discovery_en = head_ff;
    assign h2d_trig     = h2d_ff;
    assign nxt_h2d      = head_ff & cam_trig_req;

    // Head uses the discovered count; followers use lanes that toggle.
    always_comb begin
        if (lane_count == LCNT_ONE) begin
            head_mask = N_LANES'(MASK_ONE);
        end else if (lane_count == LCNT_TWO) begin
            head_mask = N_LANES'(MASK_TWO);
        end else begin
            head_mask = N_LANES'(MASK_FOUR);
        end
        nxt_seen  = seen_ff | rx_edge;
        lane_mask = head_ff ? head_mask : seen_ff;
    end

    // Transmit slots come on every clock, since the CXP-6 word time is shorter than one clock period.
    assign slot       = (tx_cnt_ff == '0);
    assign nxt_tx_cnt = slot ? TXC_W'(TX_DIV - 1) : tx_cnt_ff - 1'b1;
    assign fwd_stb    = slot;

    // Scan trigger edges and their alignment to the next line start.
    assign sos_edge = sos_s2_ff & ~sos_s3_ff;
    assign eos_edge = eos_s2_ff & ~eos_s3_ff;

    always_comb begin
        nxt_pend_sos = pend_sos_ff;
        nxt_pend_eos = pend_eos_ff;
        nxt_q_sos    = q_sos_ff;
        nxt_q_eos    = q_eos_ff;
        // Queue bits clear once their code word has gone out.
        if (slot && ms_ff == MS_CODE) begin
            if (cur_sos_ff) begin
                nxt_q_sos = 1'b0;
            end else begin
                nxt_q_eos = 1'b0;
            end
        end
        // A line start releases pending triggers; a release beats a clear.
        if (rx_edge[0] && rx_isk[0] && rx_word[0] == LINE_MARK) begin
            nxt_q_sos    = nxt_q_sos | pend_sos_ff;
            nxt_q_eos    = nxt_q_eos | pend_eos_ff;
            nxt_pend_sos = 1'b0;
            nxt_pend_eos = 1'b0;
        end
        // New triggers win over any clear in the same cycle.
        if (sos_edge && head_ff && acq_en) begin
            nxt_pend_sos = 1'b1;
        end
        if (eos_edge && head_ff && acq_en) begin
            nxt_pend_eos = 1'b1;
        end
    end

    // Message sequencer: header then code, one word per slot.
    always_comb begin
        nxt_ms      = ms_ff;
        nxt_cur_sos = cur_sos_ff;
        unique case (ms_ff)
            MS_IDLE: begin
                if (head_ff && (q_sos_ff || q_eos_ff)) begin
                    nxt_ms      = MS_HDR;
                    nxt_cur_sos = q_sos_ff;
                end
            end
            MS_HDR: begin
                if (slot) begin
                    nxt_ms = MS_CODE;
                end
            end
            MS_CODE: begin
                if (slot) begin
                    nxt_ms = MS_IDLE;
                end
            end
            default: begin
                nxt_ms = MS_IDLE;
            end
        endcase
    end

    // Message words take lane A's slot ahead of forwarded data.
    assign ins_active = (ms_ff == MS_HDR) || (ms_ff == MS_CODE);
    assign ins_word   = (ms_ff == MS_HDR) ? MSG_HDR :
                        (cur_sos_ff ? MSG_SOS : MSG_EOS);

    // Follower decodes trigger messages arriving on lane A.
    always_comb begin
        nxt_det_hdr = det_hdr_ff;
        nxt_sos_evt = 1'b0;
        nxt_eos_evt = 1'b0;
        if (rx_edge[0]) begin
            nxt_det_hdr = rx_isk[0] && rx_word[0] == MSG_HDR;
            if (det_hdr_ff && !head_ff && acq_en) begin
                nxt_sos_evt = rx_word[0] == MSG_SOS;
                nxt_eos_evt = rx_word[0] == MSG_EOS;
            end
        end
    end

    // Events go out as pulses for the event input tools.
    assign sos_evt = sos_evt_ff;
    assign eos_evt = eos_evt_ff;

    // Shared control registers.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sos_s1_ff   <= 1'b0;
            sos_s2_ff   <= 1'b0;
            sos_s3_ff   <= 1'b0;
            eos_s1_ff   <= 1'b0;
            eos_s2_ff   <= 1'b0;
            eos_s3_ff   <= 1'b0;
            pend_sos_ff <= 1'b0;
            pend_eos_ff <= 1'b0;
            q_sos_ff    <= 1'b0;
            q_eos_ff    <= 1'b0;
            ms_ff       <= MS_IDLE;
            cur_sos_ff  <= 1'b0;
            det_hdr_ff  <= 1'b0;
            sos_evt_ff  <= 1'b0;
            eos_evt_ff  <= 1'b0;
            h2d_ff      <= 1'b0;
            tx_cnt_ff   <= '0;
            seen_ff     <= '0;
        end else begin
            sos_s1_ff   <= sos_trig;
            sos_s2_ff   <= sos_s1_ff;
            sos_s3_ff   <= sos_s2_ff;
            eos_s1_ff   <= eos_trig;
            eos_s2_ff   <= eos_s1_ff;
            eos_s3_ff   <= eos_s2_ff;
            pend_sos_ff <= nxt_pend_sos;
            pend_eos_ff <= nxt_pend_eos;
            q_sos_ff    <= nxt_q_sos;
            q_eos_ff    <= nxt_q_eos;
            ms_ff       <= nxt_ms;
            cur_sos_ff  <= nxt_cur_sos;
            det_hdr_ff  <= nxt_det_hdr;
            sos_evt_ff  <= nxt_sos_evt;
            eos_evt_ff  <= nxt_eos_evt;
            h2d_ff      <= nxt_h2d;
            tx_cnt_ff   <= nxt_tx_cnt;
            seen_ff     <= nxt_seen;
        end
    end

    // One receive, buffer and transmit path per lane.
    for (genvar i = 0; i < N_LANES; i++) begin : g_lane
        logic                clk_s1_ff, clk_s2_ff, clk_s3_ff;
        logic [WORD_W-1:0]   dat_s1_ff, dat_s2_ff;
        logic                k_s1_ff, k_s2_ff;
        logic                in_valid, in_ready;
        logic                out_valid, out_ready;
        logic [WORD_W:0]     out_word;
        logic                is_idle;
        logic                ovf_ff, nxt_ovf;
        logic [WORD_W-1:0]   dat_ff, nxt_dat;
        logic                kf_ff, nxt_kf;
        logic                take_ins;

        // Link clock and data pass two flops; a rising edge takes a word.
        assign rx_edge[i] = clk_s2_ff & ~clk_s3_ff;
        assign rx_word[i] = dat_s2_ff;
        assign rx_isk[i]  = k_s2_ff;
        assign is_idle    = k_s2_ff && dat_s2_ff == IDLE_WORD;

        // Idle words and words on lanes outside lane_mask are dropped; the rest enter the buffer unless it is full, which sets ovf_ff.
        assign in_valid = rx_edge[i] & lane_mask[i] & ~is_idle;

        // Lane A yields its slot to an inserted message word.
        assign take_ins  = (i == 0) && ins_active;
        assign out_ready = slot & ~take_ins;

        // Output word per slot: message, buffered word, else idle.
        always_comb begin
            nxt_dat = dat_ff;
            nxt_kf  = kf_ff;
            nxt_ovf = ovf_ff | (in_valid & ~in_ready);
            if (slot) begin
                if (take_ins) begin
                    nxt_dat = ins_word;
                    nxt_kf  = 1'b1;
                end else if (out_valid) begin
                    nxt_dat = out_word[WORD_W-1:0];
                    nxt_kf  = out_word[WORD_W];
                end else begin
                    nxt_dat = IDLE_WORD;
                    nxt_kf  = 1'b1;
                end
            end
        end

        // Lane registers; output data always comes from flops.
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                clk_s1_ff <= 1'b0;
                clk_s2_ff <= 1'b0;
                clk_s3_ff <= 1'b0;
                dat_s1_ff <= '0;
                dat_s2_ff <= '0;
                k_s1_ff   <= 1'b0;
                k_s2_ff   <= 1'b0;
                ovf_ff    <= 1'b0;
                dat_ff    <= IDLE_WORD;
                kf_ff     <= 1'b1;
            end else begin
                clk_s1_ff <= rx_clk[i];
                clk_s2_ff <= clk_s1_ff;
                clk_s3_ff <= clk_s2_ff;
                dat_s1_ff <= rx_data[i];
                dat_s2_ff <= dat_s1_ff;
                k_s1_ff   <= rx_k[i];
                k_s2_ff   <= k_s1_ff;
                ovf_ff    <= nxt_ovf;
                dat_ff    <= nxt_dat;
                kf_ff     <= nxt_kf;
            end
        end

        // Short buffer keeps latency to a few word periods.
        fwd_word_fifo #(
            .W     (WORD_W + 1),
            .DEPTH (DEPTH)
        ) u_fifo (
            .ref_clk   (ref_clk),
            .rst_b     (rst_b),
            .in_valid  (in_valid),
            .in_ready  (in_ready),
            .in_data   ({k_s2_ff, dat_s2_ff}),
            .out_valid (out_valid),
            .out_ready (out_ready),
            .out_data  (out_word)
        );

        assign fwd_data[i]    = dat_ff;
        assign fwd_k[i]       = kf_ff;
        assign rx_overflow[i] = ovf_ff;
    end

endmodule // cxp_data_forwarding_chain

// ### cxp_cam_model.sv
`timescale 1ns/1ps
module cxp_cam_model
    import cxp_fwd_pkg::*;
(
    output logic [3:0]       rx_clk,  // Link clocks, still between words.
    output logic [3:0][31:0] rx_data, // Link words.
    output logic [3:0]       rx_k     // Control flags.
);
    int run_len = 0;

    // Links start quiet.
    initial begin
        rx_clk = '0;
        rx_data = '0;
        rx_k = '0;
    end

    // Sends one word per enabled lane over one 400 ns link period, preceded by an idle word once run_len reaches 98.
    task automatic send(input logic [3:0] en, input logic [3:0][31:0] d,
                        input logic [3:0] k);
        if (run_len >= 98) begin
            run_len = 0;
            send(en, {4{IDLE_WORD}}, 4'hf);
        end
        run_len = (k[0] && d[0] == IDLE_WORD) ? 0 : run_len + 1;
        rx_data = d;
        rx_k = k;
        #200;
        rx_clk = en;
        #200;
        rx_clk = '0;
        rx_data = ~d; // A finished word no longer stands on the line.
    endtask
endmodule // cxp_cam_model

// ### cxp_fwd_chain_props.sv
`timescale 1ns/1ps
module cxp_fwd_chain_props
    import cxp_fwd_pkg::*;
#(
    parameter int N_LANES = LANES,
    parameter int DEPTH   = FIFO_DEPTH
) (
    input wire logic                          ref_clk,      // Clock.
    input wire logic                          rst_b,        // Reset.
    input wire logic                          head_strap,   // Head.
    input wire logic [2:0]                    lane_count,   // Count.
    input wire logic                          acq_en,       // Enable.
    input wire logic                          cam_trig_req, // Trigger.
    input wire logic                          sos_trig,     // Start pin.
    input wire logic                          eos_trig,     // End pin.
    input wire logic [N_LANES-1:0]            rx_clk,       // Links.
    input wire logic [N_LANES-1:0][WORD_W-1:0] rx_data,     // Words.
    input wire logic [N_LANES-1:0]            rx_k,         // Flags.
    input wire logic [N_LANES-1:0][WORD_W-1:0] fwd_data,    // Out words.
    input wire logic [N_LANES-1:0]            fwd_k,        // Out flags.
    input wire logic                          fwd_stb,      // Slot.
    input wire logic [N_LANES-1:0]            lane_mask,    // Lanes.
    input wire logic [N_LANES-1:0]            rx_overflow,  // Lost.
    input wire logic                          discovery_en, // Head.
    input wire logic                          h2d_trig,     // Trigger.
    input wire logic                          sos_evt,      // Start.
    input wire logic                          eos_evt       // End.
);
    logic [N_LANES-1:0] exp_mask;

    // Lane mask that a head card should show for its lane count.
    always_comb begin
        case (lane_count)
            LCNT_ONE: exp_mask = N_LANES'(MASK_ONE);
            LCNT_TWO: exp_mask = N_LANES'(MASK_TWO);
            default:  exp_mask = N_LANES'(MASK_FOUR);
        endcase
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_h2d_only_head: assert property (
        h2d_trig |-> $past(cam_trig_req) && discovery_en)
        else $error("h2d trigger without head request");
    chk_h2d_follows: assert property (
        discovery_en && cam_trig_req |=> h2d_trig)
        else $error("h2d trigger missing");
    chk_head_mask: assert property (
        discovery_en && $past(discovery_en) &&
        lane_count == $past(lane_count) |-> lane_mask == exp_mask)
        else $error("head lane mask wrong");
    chk_slot_always: assert property (fwd_stb)
        else $error("transmit slot missing");
    chk_ovf_sticky: assert property (
        (~rx_overflow & $past(rx_overflow)) == '0)
        else $error("overflow flag cleared");
    chk_msg_pair: assert property (
        discovery_en && fwd_k[0] && fwd_data[0] == MSG_HDR |=>
        fwd_k[0] && (fwd_data[0] == MSG_SOS || fwd_data[0] == MSG_EOS))
        else $error("message code word missing");
    chk_evt_source: assert property (
        sos_evt || eos_evt |-> !discovery_en && $past(acq_en))
        else $error("scan event on head or disabled card");
    chk_evt_pulse: assert property (
        sos_evt || eos_evt |=> !sos_evt && !eos_evt)
        else $error("scan event longer than one cycle");
endmodule // cxp_fwd_chain_props

// ### cxp_data_forwarding_chain_test.sv
`timescale 1ns/1ps
module cxp_data_forwarding_chain_test;
    import cxp_fwd_pkg::*;
    logic             ref_clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             head_strap = 1'b0;
    logic [2:0]       lane_count = 3'h4;
    logic             acq_en = 1'b0;
    logic             cam_trig_req = 1'b0;
    logic             sos_trig = 1'b0;
    logic             eos_trig = 1'b0;
    logic [3:0]       rx_clk, rx_k, fwd_k, lane_mask, rx_overflow;
    logic [3:0][31:0] rx_data, fwd_data;
    logic             fwd_stb, discovery_en, h2d_trig, sos_evt, eos_evt;
    int               mismatches = 0;
    int               checks_done = 0;
    int               cycles = 0;
    int               cnt[4];    // Header words, starts, ends, h2d.
    bit               skip_msg = 1'b0;
    logic [32:0]      exp_q[4][$];
    logic [32:0]      got_q[4][$];
    logic [3:0]       use_mask;
    logic [3:0]       masks[3] = '{4'h1, 4'h3, 4'hf};

    cxp_cam_model cam_u (.rx_clk, .rx_data, .rx_k);
    cxp_data_forwarding_chain dut_u (.ref_clk, .rst_b, .head_strap,
        .lane_count, .acq_en, .cam_trig_req, .sos_trig, .eos_trig, .rx_clk,
        .rx_data, .rx_k, .fwd_data, .fwd_k, .fwd_stb, .lane_mask,
        .rx_overflow, .discovery_en, .h2d_trig, .sos_evt, .eos_evt);

    // Free-running 20 MHz clock.
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // Collects non-idle output words per lane and counts events.
    always @(posedge ref_clk) begin
        if (rst_b && fwd_stb === 1'b1) begin
            for (int l = 0; l < 4; l++) begin
                if (l == 0 && fwd_k[0] && fwd_data[0] == MSG_HDR)
                    cnt[0]++;
                if (!(fwd_k[l] && fwd_data[l] == IDLE_WORD) && !(skip_msg
                    && l == 0 && fwd_k[0] && fwd_data[0] != LINE_MARK))
                    got_q[l].push_back({fwd_k[l], fwd_data[l]});
            end
        end
        cnt[1] += int'(sos_evt === 1'b1);
        cnt[2] += int'(eos_evt === 1'b1);
        cnt[3] += int'(h2d_trig === 1'b1);
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Resets the card as head or follower and clears the scoreboard.
    task automatic do_reset(input logic head, input logic [3:0] mask);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        head_strap <= head;
        acq_en <= 1'b0;
        use_mask = mask;
        for (int l = 0; l < 4; l++) begin
            exp_q[l].delete();
            got_q[l].delete();
        end
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        cnt = '{default: 0};
        repeat (4) @(posedge ref_clk);
    endtask

    // Sends one word on the lanes of en and records what must come out.
    task automatic tx(input logic [3:0] en, input logic [3:0][31:0] d,
                      input logic [3:0] k);
        for (int l = 0; l < 4; l++) begin
            if (en[l] && use_mask[l] && !(k[l] && d[l] == IDLE_WORD))
                exp_q[l].push_back({k[l], d[l]});
        end
        cam_u.send(en, d, k);
    endtask

    // Random frame; idles every fifth word, data that looks idle forwarded.
    task automatic frame(input logic [3:0] en, input int n);
        logic [3:0][31:0] d;
        logic [3:0]       k;
        #7;
        for (int i = 0; i < n; i++) begin
            for (int l = 0; l < 4; l++) begin
                d[l] = $urandom();
            end
            k = (i % 5 == 0) ? 4'hf : {2'b00, i[2], 1'b0};
            if (i % 5 == 0)
                d = {4{IDLE_WORD}};
            if (i == 3)
                d[1] = IDLE_WORD;
            tx(en, d, k);
        end
        @(posedge ref_clk);
    endtask

    // Two words on lane A, the first a control word.
    task automatic lane_a(input logic [31:0] w0, w1, input logic k1);
        #7;
        tx(4'h1, {4{w0}}, 4'h1);
        tx(4'h1, {4{w1}}, {3'b000, k1});
        @(posedge ref_clk);
    endtask

    // Waits out the forwarding delay, then matches lane for lane.
    task automatic drain_and_compare();
        repeat (12) @(posedge ref_clk);
        for (int l = 0; l < 4; l++) begin
            check(33'(got_q[l].size()), 33'(exp_q[l].size()));
            while (exp_q[l].size() > 0 && got_q[l].size() > 0)
                check(got_q[l].pop_front(), exp_q[l].pop_front());
        end
    endtask

    // Trigger pins pulsed for three cycles.
    task automatic pulse(input logic s, input logic e);
        @(posedge ref_clk);
        sos_trig <= s;
        eos_trig <= e;
        repeat (3) @(posedge ref_clk);
        sos_trig <= 1'b0;
        eos_trig <= 1'b0;
        repeat (20) @(posedge ref_clk);
    endtask

    initial begin
        void'($urandom(32'hea01));
        for (int i = 0; i < 3; i++) begin
            do_reset(1'b0, masks[i]);
            check(33'(discovery_en), 33'h0);
            acq_en <= 1'b1;
            frame(masks[i], 30);
            check(33'(lane_mask), 33'(masks[i]));
            drain_and_compare();
        end
        lane_a(MSG_HDR, MSG_SOS, 1'b0);
        lane_a(MSG_HDR, MSG_EOS, 1'b1);
        @(posedge ref_clk);
        acq_en <= 1'b0;
        lane_a(MSG_HDR, MSG_SOS, 1'b1);
        drain_and_compare();
        check(33'(cnt[1]), 33'h1);
        check(33'(cnt[2]), 33'h1);
        do_reset(1'b1, 4'hf);
        skip_msg = 1'b1;
        check(33'(discovery_en), 33'h1);
        lane_count <= 3'h1;
        repeat (3) @(posedge ref_clk);
        check(33'(lane_mask), 33'(MASK_ONE));
        lane_count <= 3'h2;
        repeat (3) @(posedge ref_clk);
        check(33'(lane_mask), 33'(MASK_TWO));
        lane_count <= 3'h4;
        cam_trig_req <= 1'b1;
        @(posedge ref_clk);
        cam_trig_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(33'(cnt[3]), 33'h1);
        acq_en <= 1'b1;
        pulse(1'b1, 1'b1);
        check(33'(cnt[0]), 33'h0);
        lane_a(LINE_MARK, $urandom(), 1'b0);
        frame(4'hf, 20);
        drain_and_compare();
        check(33'(cnt[0]), 33'h2);
        acq_en <= 1'b0;
        pulse(1'b0, 1'b1);
        lane_a(LINE_MARK, $urandom(), 1'b0);
        drain_and_compare();
        check(33'(cnt[0]), 33'h2);
        check(33'(rx_overflow), 33'h0);
        tally_and_finish();
    end
endmodule // cxp_data_forwarding_chain_test

bind cxp_data_forwarding_chain cxp_fwd_chain_props #(.N_LANES(N_LANES),
    .DEPTH(DEPTH)) chk_u (.ref_clk, .rst_b, .head_strap, .lane_count,
    .acq_en, .cam_trig_req, .sos_trig, .eos_trig, .rx_clk, .rx_data, .rx_k,
    .fwd_data, .fwd_k, .fwd_stb, .lane_mask, .rx_overflow, .discovery_en,
    .h2d_trig, .sos_evt, .eos_evt);
